// file: shared/tw_cfg.svh
// Purpose: constants of the two-wire memory slave port
// Assumes: 10 MHz system clock
// Notes: definitions only
`ifndef TW_CFG_SVH
`define TW_CFG_SVH

// memory geometry
`define TW_PAGE_AW 8
`define TW_MEM_WORDS 512
// slave address layout, byte as received msb first
`define TW_TYPE_MSB 7
`define TW_TYPE_LSB 4
`define TW_SEL_MSB 3
`define TW_SEL_LSB 2
`define TW_PAGE_BIT 1
`define TW_RW_BIT 0
// ack slot index within a nine-clock byte
`define TW_ACK_SLOT 4'h8
`define TW_LAST_BIT 4'h7
// write cycle time
`define TW_WR_MS 5
`define TW_CLK_KHZ 10000
`define TW_WR_CYCLES (`TW_WR_MS * `TW_CLK_KHZ)

`endif

// file: shared/tw_pkg.sv
// Purpose: types of the two-wire memory slave port
// Assumes: nothing
// Notes: constants live in tw_cfg.svh
package tw_pkg;
    // bus-side transfer state
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_WADDR,
        ST_WDATA,
        ST_READ
    } tw_state_t;
endpackage

// file: core/tw_wrtimer.sv
// Purpose: self-timed write cycle timer on the system clock
// Assumes: stop toggle and write flag arrive from other domains
// Notes: busy level is handed back to the bus-clock domain
`timescale 1ns/100ps
`default_nettype none
`include "tw_cfg.svh"
module tw_wrtimer #(
    parameter int WR_CYCLES = `TW_WR_CYCLES
) (
    // system clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // events from the bus side, asynchronous here
    input wire logic stop_tgl,
    input wire logic wrote,
    // write cycle running
    output logic busy
);
    localparam int CW = $clog2(WR_CYCLES + 1);
    logic [2:0] stop_s_q; // sync pair plus edge history
    logic [1:0] wrote_s_q; // level sync
    logic busy_q, busy_d;
    logic [CW-1:0] cnt_q, cnt_d; // cycles left
    logic stop_p; // one cycle per stop

    // stop_s_q[0] is read only by stop_s_q[1]
    assign stop_p = stop_s_q[2] ^ stop_s_q[1];

    // start on a stop that closes a write, count down, then release
    always_comb begin
        busy_d = busy_q;
        cnt_d = cnt_q;
        if (busy_q) begin
            if (cnt_q == CW'(1)) begin
                busy_d = 1'b0;
            end
            cnt_d = cnt_q - CW'(1);
        end else if (stop_p && wrote_s_q[1]) begin
            busy_d = 1'b1;
            cnt_d = CW'(WR_CYCLES);
        end
    end

    // registers only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_s_q <= 3'h0;
            wrote_s_q <= 2'h0;
            busy_q <= 1'b0;
            cnt_q <= '0;
        end else begin
            stop_s_q <= {stop_s_q[1:0], stop_tgl};
            wrote_s_q <= {wrote_s_q[0], wrote};
            busy_q <= busy_d;
            cnt_q <= cnt_d;
        end
    end

    assign busy = busy_q;

    AST_WR_LEN: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(busy_q) |-> cnt_q == CW'(WR_CYCLES))
        else $error("write cycle loaded with wrong length");
    AST_WR_DONE: assert property (@(posedge clk) disable iff (!rst_n)
        busy_q && cnt_q == CW'(1) |=> !busy_q)
        else $error("write cycle did not end on time");
    AST_WR_STEADY: assert property (@(posedge clk) disable iff (!rst_n)
        busy_q && cnt_q > CW'(1) |=> busy_q && cnt_q == $past(cnt_q) - CW'(1))
        else $error("write cycle count disturbed");
    COV_WR: cover property (@(posedge clk) disable iff (!rst_n) $fell(busy_q));
endmodule
`default_nettype wire

// file: core/tw_slave.sv
// Purpose: slave port of a 512-byte two-wire serial memory
// Assumes: SCL is the bus clock; SDA pin given as input, output, enable
// Notes: bus side runs on SCL, start and stop on SDA edges, write timing on CLK
`timescale 1ns/100ps
`default_nettype none
`include "tw_cfg.svh"
module tw_slave
    import tw_pkg::*;
#(
    parameter logic [3:0] DEV_TYPE = 4'h5, // type code, value arbitrary
    parameter int WR_CYCLES = `TW_WR_CYCLES
) (
    // system clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // two-wire bus
    input wire logic SCL,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE,
    // address straps
    input wire logic UNUSED_STRAP_INPUT,
    input wire logic DEVICE_SELECT_STRAP_LOW,
    input wire logic DEVICE_SELECT_STRAP_HIGH
);
    logic [7:0] mem [0:`TW_MEM_WORDS-1]; // storage, both pages
    tw_state_t state_q, state_d;
    logic [3:0] bitc_q, bitc_d; // 0..7 data bits, 8 ack slot
    logic [6:0] sr_q, sr_d; // bits received so far
    logic [7:0] addr_q, addr_d; // word address in page
    logic page_q, page_d; // selected page
    logic ack_q, ack_d; // drive ack in coming slot
    logic first_q, first_d; // first read byte pending
    logic wrote_q, wrote_d; // a byte written this frame
    logic [7:0] tx_q, tx_d; // byte being sent
    logic start_ack_q, start_ack_d; // last start taken
    logic start_tgl_q, start_tgl_d; // flips on each start
    logic stop_tgl_q, stop_tgl_d; // flips on each stop
    logic oe_q, oe_d; // pull-down, changes on SCL fall
    logic [1:0] busy_s_q; // busy synced to SCL
    logic [1:0] sel_lo_s_q, sel_hi_s_q; // straps synced to SCL
    logic busy_wr; // busy in CLK domain
    logic [7:0] byte_in; // full byte on eighth bit
    logic start_pend; // start seen, not yet taken
    logic match; // address byte is ours
    logic mem_we; // store byte_in
    logic [8:0] mem_wa;

    // start and stop are data edges while the clock is high
    assign start_tgl_d = SCL ? ~start_tgl_q : start_tgl_q;
    assign stop_tgl_d = SCL ? ~stop_tgl_q : stop_tgl_q;

    // start detector clocked by the falling data line
    always_ff @(negedge SDA_I or negedge RST_N) begin
        if (!RST_N) begin
            start_tgl_q <= 1'b0;
        end else begin
            start_tgl_q <= start_tgl_d;
        end
    end

    // stop detector clocked by the rising data line
    always_ff @(posedge SDA_I or negedge RST_N) begin
        if (!RST_N) begin
            stop_tgl_q <= 1'b0;
        end else begin
            stop_tgl_q <= stop_tgl_d;
        end
    end

    // start toggle read directly: hold time before first SCL rise keeps it settled
    assign start_pend = start_tgl_q ^ start_ack_q;
    assign byte_in = {sr_q, SDA_I};
    // lowest strap is left unread on purpose
    assign match = byte_in[`TW_TYPE_MSB:`TW_TYPE_LSB] == DEV_TYPE
        && byte_in[`TW_SEL_MSB:`TW_SEL_LSB] == {sel_hi_s_q[1], sel_lo_s_q[1]}
        && !busy_s_q[1];

    // bit sequencing, sampled on SCL rise
    always_comb begin
        state_d = state_q;
        bitc_d = bitc_q;
        sr_d = sr_q;
        addr_d = addr_q;
        page_d = page_q;
        ack_d = ack_q;
        first_d = first_q;
        wrote_d = wrote_q;
        tx_d = tx_q;
        start_ack_d = start_ack_q;
        mem_we = 1'b0;
        mem_wa = {page_q, addr_q};
        if (start_pend) begin
            // this rise carries the first address bit
            start_ack_d = start_tgl_q;
            state_d = ST_ADDR;
            bitc_d = 4'h1;
            sr_d = {6'h00, SDA_I};
            ack_d = 1'b0;
            wrote_d = 1'b0;
        end else if (state_q != ST_IDLE) begin
            if (bitc_q == `TW_ACK_SLOT) begin
                bitc_d = 4'h0;
                ack_d = 1'b0;
                if (state_q == ST_READ) begin
                    // master ack low asks for the next byte
                    if (first_q || !SDA_I) begin
                        tx_d = mem[{page_q, addr_q}];
                        addr_d = addr_q + 8'h01; // full page wrap on reads
                        first_d = 1'b0;
                    end else begin
                        state_d = ST_IDLE;
                    end
                end
            end else begin
                sr_d = byte_in[6:0];
                bitc_d = bitc_q + 4'h1;
                if (bitc_q == `TW_LAST_BIT) begin
                    case (state_q)
                        ST_ADDR: begin
                            if (match) begin
                                ack_d = 1'b1;
                                page_d = byte_in[`TW_PAGE_BIT];
                                first_d = 1'b1;
                                state_d = byte_in[`TW_RW_BIT] ? ST_READ : ST_WADDR;
                            end else begin
                                state_d = ST_IDLE;
                            end
                        end
                        ST_WADDR: begin
                            addr_d = byte_in;
                            ack_d = 1'b1;
                            state_d = ST_WDATA;
                        end
                        ST_WDATA: begin
                            mem_we = 1'b1;
                            wrote_d = 1'b1;
                            ack_d = 1'b1;
                            addr_d = {addr_q[7:3], addr_q[2:0] + 3'h1};
                        end
                        default: begin
                            ack_d = 1'b0; // master acks reads
                        end
                    endcase
                end
            end
        end
    end

    // bus-side registers, SCL rise
    always_ff @(posedge SCL or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= ST_IDLE;
            bitc_q <= 4'h0;
            sr_q <= 7'h00;
            addr_q <= 8'h00;
            page_q <= 1'b0;
            ack_q <= 1'b0;
            first_q <= 1'b0;
            wrote_q <= 1'b0;
            tx_q <= 8'h00;
            start_ack_q <= 1'b0;
            busy_s_q <= 2'h0;
            sel_lo_s_q <= 2'h0;
            sel_hi_s_q <= 2'h0;
        end else begin
            state_q <= state_d;
            bitc_q <= bitc_d;
            sr_q <= sr_d;
            addr_q <= addr_d;
            page_q <= page_d;
            ack_q <= ack_d;
            first_q <= first_d;
            wrote_q <= wrote_d;
            tx_q <= tx_d;
            start_ack_q <= start_ack_d;
            busy_s_q <= {busy_s_q[0], busy_wr};
            sel_lo_s_q <= {sel_lo_s_q[0], DEVICE_SELECT_STRAP_LOW};
            sel_hi_s_q <= {sel_hi_s_q[0], DEVICE_SELECT_STRAP_HIGH};
        end
    end

    // storage has no reset, contents survive bus reset
    always_ff @(posedge SCL) begin
        if (mem_we) begin
            mem[mem_wa] <= byte_in;
        end
    end

    // pull-down decision, changes on SCL rise; reaches the pin on SCL fall
    always_comb begin
        oe_d = 1'b0;
        if (bitc_q == `TW_ACK_SLOT) begin
            oe_d = ack_q;
        end else if (state_q == ST_READ) begin
            oe_d = !tx_q[~bitc_q[2:0]]; // msb first
        end
    end

    // output register on SCL fall
    always_ff @(negedge SCL or negedge RST_N) begin
        if (!RST_N) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= oe_d;
        end
    end

    // open drain: only low or released; released while writing
    assign SDA_O = 1'b0;
    assign SDA_OE = oe_q && !busy_s_q[1];

    // write cycle timer on the system clock
    tw_wrtimer #(
        .WR_CYCLES(WR_CYCLES)
    ) u_timer (
        .clk(CLK),
        .rst_n(RST_N),
        .stop_tgl(stop_tgl_q),
        .wrote(wrote_q),
        .busy(busy_wr)
    );

    AST_NO_ACK_BUSY: assert property (@(posedge SCL) disable iff (!RST_N)
        state_q == ST_ADDR && bitc_q == 4'h7 && busy_s_q[1] && !start_pend
        |=> !ack_q ##1 !ack_q)
        else $error("address acknowledged during write cycle");
    // type and select rebuilt from the shift register, so a broken match still fires
    AST_ADDR_MATCH: assert property (@(posedge SCL) disable iff (!RST_N)
        state_q == ST_ADDR && bitc_q == 4'h7 && !start_pend && !busy_s_q[1]
        && sr_q[6:3] == DEV_TYPE && sr_q[2:1] == {sel_hi_s_q[1], sel_lo_s_q[1]}
        |=> ack_q && bitc_q == 4'h8)
        else $error("matching address not acknowledged");
    AST_PAGE_SEL: assert property (@(posedge SCL) disable iff (!RST_N)
        state_q == ST_ADDR && bitc_q == 4'h7 && match && !start_pend
        |=> page_q == $past(sr_q[0]))
        else $error("page bit not taken");
    AST_READ_DIR: assert property (@(posedge SCL) disable iff (!RST_N)
        state_q == ST_ADDR && bitc_q == 4'h7 && match && SDA_I && !start_pend
        |=> state_q == ST_READ)
        else $error("read bit not honoured");
    AST_WRAP: assert property (@(posedge SCL) disable iff (!RST_N)
        state_q == ST_WDATA && bitc_q == 4'h7 && !start_pend
        |=> addr_q[2:0] == $past(addr_q[2:0]) + 3'h1 && addr_q[7:3] == $past(addr_q[7:3]))
        else $error("page write address step wrong");
    AST_STORE: assert property (@(posedge SCL) disable iff (!RST_N)
        mem_we |=> mem[$past(mem_wa)] == $past(byte_in))
        else $error("written byte not stored");
    AST_ACK_DRIVE: assert property (@(posedge SCL) disable iff (!RST_N)
        bitc_q == 4'h8 && ack_q && !busy_s_q[1] && !start_pend |-> SDA_OE)
        else $error("ack slot not pulled low");
    COV_READ: cover property (@(posedge SCL) disable iff (!RST_N)
        state_q == ST_READ && bitc_q == 4'h8 && !SDA_I);
    COV_WRITE: cover property (@(posedge SCL) disable iff (!RST_N) mem_we);
    COV_POLL: cover property (@(posedge SCL) disable iff (!RST_N)
        state_q == ST_ADDR && bitc_q == 4'h7 && busy_s_q[1]);
endmodule
`default_nettype wire

// file: verification/tw_master.sv
// Purpose: behavioural two-wire bus master facing the memory port
// Assumes: pull-up on the data wire, 125 ns bus clock period
// Notes: clock stands high between frames, never free-running
`timescale 1ns/100ps
`default_nettype none
module tw_master (
    // bus clock and data pull-down
    output logic scl,
    output logic sda_low,
    // resolved data wire level
    input wire logic sda
);
    localparam realtime Q = 31.25; // quarter bus clock period

    // idle bus: clock high, data released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // one bit: data moves mid-low, sampled mid-high
    task automatic bit_io(input logic b, output logic r);
        #Q sda_low = ~b;
        #Q scl = 1'b1;
        #Q r = sda;
        #Q scl = 1'b0;
    endtask

    // start or repeated start: data falls while clock high
    task automatic start();
        #Q sda_low = 1'b0;
        #Q scl = 1'b1;
        #(2*Q) sda_low = 1'b1;
        #Q scl = 1'b0;
    endtask

    // stop: data rises while clock high, clock then stays high
    task automatic stop();
        #Q sda_low = 1'b1;
        #Q scl = 1'b1;
        #Q sda_low = 1'b0;
        #Q;
    endtask

    // byte out, then release for the slave's acknowledge
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    // byte in with line released, then our own ack or nack
    task automatic recv(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(nack, r);
    endtask
endmodule
`default_nettype wire

// file: verification/two_wire_eeprom_slave_port_bench.sv
// Purpose: self-checking bench of the two-wire memory slave port
// Assumes: write time shortened to 200 system clocks
// Notes: straps fixed at select 2'b10, lowest strap tied low
`timescale 1ns/100ps
`default_nettype none
module two_wire_eeprom_slave_port_bench;
    localparam int WR_CYC = 200; // short write cycle keeps run brief
    localparam logic [3:0] DTYPE = 4'h5; // type code, value arbitrary
    logic clk, rst_n, strap_lo, strap_hi, scl, m_low, sda_o, sda_oe;
    wire sda;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;

    // wired-AND with pull-up: high unless someone pulls
    assign sda = ~(m_low | sda_oe);

    tw_slave #(.DEV_TYPE(DTYPE), .WR_CYCLES(WR_CYC)) dut_u (
        .CLK(clk), .RST_N(rst_n), .SCL(scl), .SDA_I(sda), .SDA_O(sda_o),
        .SDA_OE(sda_oe), .UNUSED_STRAP_INPUT(1'b0),
        .DEVICE_SELECT_STRAP_LOW(strap_lo), .DEVICE_SELECT_STRAP_HIGH(strap_hi));
    tw_master bus_u (.scl(scl), .sda_low(m_low), .sda(sda));

    always #50 clk = ~clk;

    // hang guard, far beyond the expected thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            finish_test();
        end
    end

    // open drain: the driven value is never high
    always @(posedge clk) begin
        if (rst_n && sda_o !== 1'b0) begin
            fail("data output not low");
        end
    end

    task automatic fail(input string m);
        bad_count++;
        $display("CHECK FAILED at %0t: %s", $time, m);
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            fail(m);
        end
    endtask

    // slave byte: type, select, page, direction
    function automatic logic [7:0] sa(input logic [1:0] s, input logic pg, input logic rd);
        return {DTYPE, s, pg, rd};
    endfunction

    // acknowledge polling; n counts frames up to the first ack
    task automatic poll(output int n);
        logic a;
        n = 0;
        a = 1'b0;
        while (!a && n < 60) begin
            bus_u.start();
            bus_u.send(sa(2'b10, 1'b0, 1'b0), a);
            bus_u.stop();
            n++;
        end
    endtask

    // random read of one byte, ended by nack and stop
    task automatic rd1(input logic pg, input logic [7:0] ad, output logic [7:0] d);
        logic a;
        bus_u.start();
        bus_u.send(sa(2'b10, pg, 1'b0), a);
        bus_u.send(ad, a);
        bus_u.start();
        bus_u.send(sa(2'b10, pg, 1'b1), a);
        bus_u.recv(1'b1, d);
        bus_u.stop();
    endtask

    // only the strapped select and our type get an ack
    task automatic t_select();
        logic a;
        for (int s = 0; s < 4; s++) begin
            bus_u.start();
            bus_u.send(sa(s[1:0], 1'b0, 1'b0), a);
            bus_u.stop();
            cmp({7'h0, a}, {7'h0, s == 2}, "select match");
        end
        bus_u.start();
        bus_u.send({~DTYPE, 4'h8}, a);
        bus_u.stop();
        cmp({7'h0, a}, 8'h00, "foreign type acked");
    endtask

    // nine bytes from 0x3e: low three bits wrap, ninth overwrites
    task automatic t_page_write();
        logic a;
        logic [7:0] d;
        int n;
        bus_u.start();
        bus_u.send(sa(2'b10, 1'b1, 1'b0), a);
        cmp({7'h0, a}, 8'h01, "address not acked");
        bus_u.send(8'h3e, a);
        for (int i = 0; i < 9; i++) begin
            bus_u.send(8'h10 + i[7:0], a);
            cmp({7'h0, a}, 8'h01, "data not acked");
        end
        bus_u.stop();
        poll(n);
        total_checks++;
        // each poll frame is about 1.4 us, busy is 20 us
        if (n < 13 || n > 18) fail("write busy time off");
        bus_u.start();
        bus_u.send(sa(2'b10, 1'b1, 1'b0), a);
        bus_u.send(8'h38, a);
        bus_u.start();
        bus_u.send(sa(2'b10, 1'b1, 1'b1), a);
        for (int i = 0; i < 8; i++) begin
            bus_u.recv(i == 7, d);
            cmp(d, (i == 7) ? 8'h11 : 8'h12 + i[7:0], "page wrap data");
        end
        bus_u.stop();
    endtask

    // same word address in the other page stays apart
    task automatic t_pages();
        logic a;
        logic [7:0] d;
        int n;
        bus_u.start();
        bus_u.send(sa(2'b10, 1'b0, 1'b0), a);
        bus_u.send(8'h38, a);
        bus_u.send(8'ha5, a);
        bus_u.stop();
        poll(n);
        total_checks++;
        // a single byte write busies the port for the same time
        if (n < 13 || n > 18) fail("byte write busy time off");
        rd1(1'b0, 8'h38, d);
        cmp(d, 8'ha5, "page 0 data");
        rd1(1'b1, 8'h38, d);
        cmp(d, 8'h12, "page 1 disturbed");
    endtask

    task automatic finish_test();
        if (bad_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // main sequence: straps fixed from time zero
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        strap_lo = 1'b0;
        strap_hi = 1'b1;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #37; // keep bus edges off the system clock edges
        t_select();
        t_page_write();
        t_pages();
        finish_test();
    end
endmodule
`default_nettype wire
